//--- seq_ctl_pkg.sv
// Package for the sequencer control register bank: offsets, fields, timing.
// Assumes a single 250 MHz system clock and byte addressed 32-bit words.
package seq_ctl_pkg;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_LED_SELECT = 8'h00;
    localparam logic [7:0] OFS_SERIAL = 8'h04;
    localparam logic [7:0] OFS_TEMPERATURE = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IDENTITY = 8'h14;
    localparam logic [7:0] OFS_FIRMWARE = 8'h18;
    localparam logic [7:0] OFS_INTEG_TIME = 8'h1c;

    // Reset values
    localparam logic [2:0] LED_SELECT_RST = 3'h0;
    localparam logic [15:0] CONTROL_RST = 16'h0000;

    // Field widths and positions
    localparam int TEMP_W = 10;
    localparam int LED_W = 3;
    localparam int PC_STATUS_W = 8;
    localparam int STAT_RUN_BIT = 8;
    localparam int STAT_ITC_BIT = 9;
    localparam int STAT_SYNC_BIT = 10;

    // Microcode enables bit positions
    localparam int EN_CLR_START_EXP = 0;
    localparam int EN_ITC_START = 1;
    localparam int EN_ITC_STOP = 2;
    localparam int EN_AUTOCANCEL_ON = 8;
    localparam int EN_AUTOCANCEL_OFF = 9;
    localparam int EN_SYNC_LOW = 14;
    localparam int EN_SYNC_HIGH = 15;

    // Timing
    localparam int SEQ_BASE_NS = 50;
    localparam int SEQ_BASE_CYC = (SEQ_BASE_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
        (SEQ_BASE_NS * 1000 / CLK_PERIOD_PS);
    localparam int LED_FLASH_MS = 10;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYC_DEFAULT = MS_PS / CLK_PERIOD_PS;

    // Control register layout
    typedef struct packed {
        logic [7:0] sync_emit_delay;
        logic [2:0] unused;
        logic chassis_master_select;
        logic [1:0] instruction_rate_divider;
        logic integration_pause;
        logic run_enable;
    } seq_ctl_t;

    // Masked sequencer bus signals
    typedef struct packed {
        logic [7:0] board_sel;
        logic bus_req;
    } seq_bus_t;

    typedef enum logic {
        SEQ_HALT = 1'b0,
        SEQ_RUN = 1'b1
    } seq_state_t;

endpackage

//--- flash_timer.sv
// Retriggerable flash timer: holds its output for a fixed number of cycles.
// Assumes trigger is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module flash_timer #(
    parameter int COUNT = 2500000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic trig,
    output logic busy
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    wire done = cnt_reg == '0;

    assign cnt_next = trig ? LOAD : (done ? cnt_reg : cnt_reg - CW'(1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            busy <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            busy <= trig | (cnt_reg > CW'(1));
        end
    end
endmodule // flash_timer

//--- seq_ctl_regs.sv
// Sequencer control and status register bank with sequencer run control.
// Assumes host accesses arrive as one-cycle strobes on clk_sys.
//
// Summary of operation
// - LED select bits pick three flash triggers
// - LED lit until link up, then flashes
// - Serial register returns 32-bit board serial
// - Temperature reads 10-bit signed quarter degrees
// - Run enable starts microcode execution
// - Clearing run finishes instruction, masks, resets pc
// - Pause bit freezes integration time counter
// - Divider code picks 48 to 384 ns
// - One instruction per sequencer clock tick
// - Master bit drives sync out, else input
// - Master sync bit follows set/reset flop
// - Sync out held for millisecond delay field after low
// - Status read-only, shows low pc bits
// - Identity read returns board type code
// - Identity write causes soft reset
// - Firmware read returns revision times hundred
// - Firmware write causes hard reset boot
// - Enables register written only by microcode
// - Enables bit 0 clears start exposure
// - Bits 1 and 2 start, stop counter
// - Bits 8 and 9 turn auto-cancel on, off
// - Bits 15 and 14 drive sync high, low
`timescale 1ns/1ps
module seq_ctl_regs
    import seq_ctl_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEFAULT,
    parameter logic [15:0] IDENTITY_CODE = 16'h0a5c,
    parameter logic [15:0] FIRMWARE_REV = 16'h0064
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic host_word_rx,
    input wire logic host_cmd_bus_req,
    input wire logic link_established,
    output logic led_on,
    input wire logic [31:0] serial_number_in,
    input wire logic [TEMP_W-1:0] temp_value_in,
    output logic temp_start,
    input wire logic [15:0] seq_pc_in,
    input wire logic [7:0] seq_board_sel_in,
    input wire logic seq_bus_req_in,
    output logic seq_tick,
    output logic seq_running,
    output logic seq_pc_clear,
    output seq_bus_t seq_bus_out,
    input wire logic mc_en_wr,
    input wire logic [31:0] mc_en_data,
    output logic clear_start_exposure,
    output logic autocancel_on,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_out_oe,
    output logic cmd_sync,
    output logic soft_reset,
    output logic boot_n
);
    // Reset release
    logic [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Address decode
    wire hit_led = reg_addr == OFS_LED_SELECT;
    wire hit_ser = reg_addr == OFS_SERIAL;
    wire hit_temp = reg_addr == OFS_TEMPERATURE;
    wire hit_ctl = reg_addr == OFS_CONTROL;
    wire hit_stat = reg_addr == OFS_STATUS;
    wire hit_id = reg_addr == OFS_IDENTITY;
    wire hit_fw = reg_addr == OFS_FIRMWARE;
    wire hit_itc = reg_addr == OFS_INTEG_TIME;
    wire wr_led = reg_wr & hit_led;
    wire wr_temp = reg_wr & hit_temp;
    wire wr_ctl = reg_wr & hit_ctl;
    wire wr_id = reg_wr & hit_id;
    wire wr_fw = reg_wr & hit_fw;

    // Microcode enables commands, decoded only from the microcode port
    wire en_clr_se = mc_en_wr & mc_en_data[EN_CLR_START_EXP];
    wire en_itc_start = mc_en_wr & mc_en_data[EN_ITC_START];
    wire en_itc_stop = mc_en_wr & mc_en_data[EN_ITC_STOP];
    wire en_ac_on = mc_en_wr & mc_en_data[EN_AUTOCANCEL_ON];
    wire en_ac_off = mc_en_wr & mc_en_data[EN_AUTOCANCEL_OFF];
    wire en_sync_lo = mc_en_wr & mc_en_data[EN_SYNC_LOW];
    wire en_sync_hi = mc_en_wr & mc_en_data[EN_SYNC_HIGH];

    // Software registers
    logic [LED_W-1:0] led_select_reg;
    seq_ctl_t ctl_reg;
    seq_ctl_t ctl_next;

    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl) begin
            ctl_next = seq_ctl_t'(reg_wdata[15:0]);
            ctl_next.unused = 3'h0;
        end
        if (wr_id) begin
            ctl_next.run_enable = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            led_select_reg <= LED_SELECT_RST;
            ctl_reg <= seq_ctl_t'(CONTROL_RST);
        end else begin
            if (wr_led) begin
                led_select_reg <= reg_wdata[LED_W-1:0];
            end
            ctl_reg <= ctl_next;
        end
    end

    // Resets and temperature conversion start requested by the host
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset <= 1'b0;
            boot_n <= 1'b1;
            temp_start <= 1'b0;
        end else begin
            soft_reset <= wr_id;
            temp_start <= wr_temp;
            if (wr_fw) begin
                boot_n <= 1'b0;
            end
        end
    end

    // Millisecond tick
    localparam int MSW = $clog2(MS_CYC + 1);
    logic [MSW-1:0] ms_cnt_reg;
    wire ms_tick = ms_cnt_reg == '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_reg <= MSW'(MS_CYC - 1);
        end else begin
            ms_cnt_reg <= ms_tick ? MSW'(MS_CYC - 1) : ms_cnt_reg - MSW'(1);
        end
    end

    // Instruction rate divider
    logic [7:0] div_cnt_reg;
    wire [7:0] div_load = 8'((SEQ_BASE_CYC << ctl_reg.instruction_rate_divider) - 1);
    wire div_wrap = div_cnt_reg == 8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 8'h00;
            seq_tick <= 1'b0;
        end else begin
            div_cnt_reg <= div_wrap ? div_load : div_cnt_reg - 8'h01;
            seq_tick <= div_wrap;
        end
    end

    // Sequencer run state
    seq_state_t state_reg;
    seq_state_t state_next;
    wire tick_now = div_wrap;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_HALT: begin
                if (tick_now && ctl_reg.run_enable) begin
                    state_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (tick_now && !ctl_reg.run_enable) begin
                    state_next = SEQ_HALT;
                end
            end
        endcase
    end

    wire running_next = state_next == SEQ_RUN;
    wire stopping = (state_reg == SEQ_RUN) && (state_next == SEQ_HALT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SEQ_HALT;
            seq_running <= 1'b0;
            seq_pc_clear <= 1'b0;
            seq_bus_out <= '0;
        end else begin
            state_reg <= state_next;
            seq_running <= running_next;
            seq_pc_clear <= stopping;
            seq_bus_out.board_sel <= running_next ? seq_board_sel_in : 8'h00;
            seq_bus_out.bus_req <= running_next & seq_bus_req_in;
        end
    end

    // Integration time counter, counts milliseconds
    logic itc_run_reg;
    logic [31:0] itc_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            itc_run_reg <= 1'b0;
            itc_reg <= 32'h0000_0000;
        end else begin
            if (en_itc_stop) begin
                itc_run_reg <= 1'b0;
            end else if (en_itc_start) begin
                itc_run_reg <= 1'b1;
            end
            if (en_itc_start && !en_itc_stop) begin
                itc_reg <= 32'h0000_0000;
            end else if (itc_run_reg && ms_tick && !ctl_reg.integration_pause) begin
                itc_reg <= itc_reg + 32'h0000_0001;
            end
        end
    end

    // Start exposure clear and auto-cancel mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clear_start_exposure <= 1'b0;
            autocancel_on <= 1'b0;
        end else begin
            clear_start_exposure <= en_clr_se;
            if (en_ac_off) begin
                autocancel_on <= 1'b0;
            end else if (en_ac_on) begin
                autocancel_on <= 1'b1;
            end
        end
    end

    // Sync set/reset flop and delayed emission
    logic sync_rs_reg;
    logic sync_delay_reg;
    logic [7:0] sync_cnt_reg;
    logic [2:0] sync_in_reg;
    logic sync_in_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_rs_reg <= 1'b0;
            sync_delay_reg <= 1'b0;
            sync_cnt_reg <= 8'h00;
            sync_out <= 1'b0;
        end else begin
            if (en_sync_lo) begin
                sync_rs_reg <= 1'b0;
                sync_delay_reg <= sync_rs_reg | sync_delay_reg;
                sync_cnt_reg <= sync_rs_reg ? ctl_reg.sync_emit_delay : sync_cnt_reg;
            end else if (en_sync_hi) begin
                sync_rs_reg <= 1'b1;
                sync_delay_reg <= 1'b0;
                sync_out <= 1'b1;
            end else if (sync_delay_reg && ms_tick) begin
                if (sync_cnt_reg == 8'h00) begin
                    sync_delay_reg <= 1'b0;
                    sync_out <= 1'b0;
                end else begin
                    sync_cnt_reg <= sync_cnt_reg - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_in_reg <= 3'h0;
            sync_in_q <= 1'b0;
            sync_out_oe <= 1'b0;
            cmd_sync <= 1'b0;
        end else begin
            sync_in_reg <= {sync_in_reg[1:0], sync_in};
            if (sync_in_reg[2] == sync_in_reg[1]) begin
                sync_in_q <= sync_in_reg[2];
            end
            sync_out_oe <= ctl_reg.chassis_master_select;
            cmd_sync <= ctl_reg.chassis_master_select ? sync_rs_reg : sync_in_q;
        end
    end

    // Indicator LED
    logic link_up_reg;
    logic flash_busy;
    wire flash_trig = link_up_reg & |({seq_bus_req_in, host_cmd_bus_req, host_word_rx}
        & led_select_reg);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_up_reg <= 1'b0;
            led_on <= 1'b1;
        end else begin
            if (link_established) begin
                link_up_reg <= 1'b1;
            end
            led_on <= !link_up_reg | flash_busy;
        end
    end

    flash_timer #(
        .COUNT(LED_FLASH_MS * MS_CYC)
    ) u_flash (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .trig(flash_trig),
        .busy(flash_busy)
    );

    // Read data
    wire [15:0] status_word = {5'h00, sync_out, itc_run_reg, seq_running,
        seq_pc_in[PC_STATUS_W-1:0]};
    wire [DATA_W-1:0] rd_mux =
        hit_led ? {29'h0, led_select_reg} :
        hit_ser ? serial_number_in :
        hit_temp ? {22'h0, temp_value_in} :
        hit_ctl ? {16'h0, ctl_reg} :
        hit_stat ? {16'h0, status_word} :
        hit_id ? {16'h0, IDENTITY_CODE} :
        hit_fw ? {16'h0, FIRMWARE_REV} :
        hit_itc ? itc_reg : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule // seq_ctl_regs

//--- seq_ctl_regs_properties.sv
// Port assertions for the sequencer control register bank.
// Bound into seq_ctl_regs; sees only its ports, single clock domain.
`timescale 1ns/1ps
module seq_ctl_regs_properties
    import seq_ctl_pkg::*;
#(
    parameter logic [15:0] IDENTITY_CODE = 16'h0a5c,
    parameter logic [15:0] FIRMWARE_REV = 16'h0064
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic temp_start,
    input wire logic seq_tick,
    input wire logic seq_running,
    input wire seq_bus_t seq_bus_out,
    input wire logic mc_en_wr,
    input wire logic [31:0] mc_en_data,
    input wire logic clear_start_exposure,
    input wire logic autocancel_on,
    input wire logic sync_out,
    input wire logic soft_reset,
    input wire logic boot_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    ident_read_a: assert property (reg_rd && reg_addr == OFS_IDENTITY |=>
        reg_rdata == {16'h0, IDENTITY_CODE}) else $error("identity read wrong");
    fw_read_a: assert property (reg_rd && reg_addr == OFS_FIRMWARE |=>
        reg_rdata == {16'h0, FIRMWARE_REV}) else $error("firmware read wrong");
    temp_start_a: assert property (reg_wr && reg_addr == OFS_TEMPERATURE |=>
        temp_start ##1 !temp_start) else $error("no temperature start pulse");
    soft_reset_a: assert property (reg_wr && reg_addr == OFS_IDENTITY |=>
        soft_reset ##[0:100] !seq_running) else $error("soft reset did not halt");
    boot_low_a: assert property (reg_wr && reg_addr == OFS_FIRMWARE |=>
        !boot_n [*3]) else $error("boot not held low");
    halt_mask_a: assert property (!seq_running && !$past(seq_running) |->
        seq_bus_out == '0) else $error("bus not masked while halted");
    tick_gap_a: assert property (seq_tick |=> !seq_tick [*8])
        else $error("ticks too close");
    sync_high_a: assert property (mc_en_wr && mc_en_data[15] && !mc_en_data[14]
        |=> sync_out) else $error("sync not driven high");
    cancel_on_a: assert property (mc_en_wr && mc_en_data[8] && !mc_en_data[9]
        |=> autocancel_on) else $error("auto cancel not on");
    cancel_wins_a: assert property (mc_en_wr && mc_en_data[9] |=> !autocancel_on)
        else $error("auto cancel not off");
    start_exp_a: assert property (mc_en_wr |=>
        clear_start_exposure == $past(mc_en_data[0])) else $error("start flag clear wrong");

    cover property (soft_reset);
    cover property ($rose(sync_out));
    cover property (seq_tick && seq_running);
endmodule // seq_ctl_regs_properties

bind seq_ctl_regs seq_ctl_regs_properties #(.IDENTITY_CODE(IDENTITY_CODE),
    .FIRMWARE_REV(FIRMWARE_REV)) i_props (.*);

//--- board_side_model.sv
// Model of the board parts around the register bank: sensor, serial, sequencer.
// Assumes one clock; the temperature is only valid after a conversion.
`timescale 1ns/1ps
module board_side_model #(
    parameter logic [31:0] SERIAL = 32'h5eed_0001,
    parameter logic [9:0] TEMP = 10'h3f6,
    parameter int CONV = 6000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic temp_start,
    input wire logic seq_tick,
    input wire logic seq_running,
    input wire logic seq_pc_clear,
    output logic [31:0] serial_number_in,
    output logic [9:0] temp_value_in,
    output logic [15:0] seq_pc_in,
    output logic [7:0] seq_board_sel_in,
    output logic seq_bus_req_in,
    output logic sync_in
);
    int conv_cnt;
    assign serial_number_in = SERIAL;
    assign seq_board_sel_in = seq_pc_in[7:0] | 8'h01;
    assign seq_bus_req_in = 1'b1;
    // Neighbour chassis sync held high while a conversion runs
    assign sync_in = conv_cnt != 0;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            conv_cnt <= 0;
            temp_value_in <= ~TEMP;
            seq_pc_in <= 16'h0;
        end else begin
            // Stale inverse value while converting
            if (temp_start) begin
                conv_cnt <= CONV;
                temp_value_in <= ~TEMP;
            end else if (conv_cnt == 1) begin
                temp_value_in <= TEMP;
            end
            if (!temp_start && conv_cnt != 0) begin
                conv_cnt <= conv_cnt - 1;
            end
            // Program counter only advances while the sequencer runs
            if (seq_pc_clear) begin
                seq_pc_in <= 16'h0;
            end else if (seq_tick && seq_running) begin
                seq_pc_in <= seq_pc_in + 16'h1;
            end
        end
    end
endmodule // board_side_model

//--- tb_seq_ctl_regs.sv
// Self-checking bench for seq_ctl_regs with the board side model.
// Assumes a 250 MHz clock and a 10 cycle millisecond for speed.
`timescale 1ns/1ps
module tb_seq_ctl_regs;
    import seq_ctl_pkg::*;
    localparam logic [15:0] ID = 16'h0b0d; // Arbitrary board type code
    localparam logic [9:0] TEMP = 10'h3f6;
    localparam logic [31:0] SERIAL = 32'h5eed_0001; // Arbitrary serial value
    logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, mc_en_wr = 0;
    logic host_word_rx = 0, host_cmd_bus_req = 0, link_established = 0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, mc_en_data = 32'h0, reg_rdata, serial_number_in, v;
    logic [9:0] temp_value_in;
    logic [15:0] seq_pc_in;
    logic [7:0] seq_board_sel_in;
    logic seq_bus_req_in, sync_in, led_on, temp_start, seq_tick, seq_running, seq_pc_clear;
    logic clear_start_exposure, autocancel_on, sync_out, sync_out_oe, cmd_sync;
    logic soft_reset, boot_n;
    seq_bus_t seq_bus_out;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int checks = 0, bad_count = 0, cycles = 0, seed;

    seq_ctl_regs #(.MS_CYC(10), .IDENTITY_CODE(ID)) i_dut (.*);
    board_side_model #(.SERIAL(SERIAL), .TEMP(TEMP)) i_board (.*);

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic mc_en(input logic [31:0] d);
        mc_en_data <= d;
        mc_en_wr <= 1'b1;
        @(posedge clk_sys);
        mc_en_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done;
        end
    end

    always @(negedge clk_sys) begin
        if (rd_d) begin
            chk(nm_q.pop_front(), exp_q.pop_front(), reg_rdata);
        end
    end

    initial begin
        seed = 66933;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("led before link", 32'h1, {31'h0, led_on});
        rd(OFS_IDENTITY, {16'h0, ID}, "identity");
        rd(OFS_FIRMWARE, 32'h64, "firmware");
        rd(OFS_SERIAL, SERIAL, "serial");
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS, 32'h0, "status halted");
        rd(8'h3c, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(OFS_LED_SELECT, v);
            rd(OFS_LED_SELECT, v & 32'h7, "led select");
            wr(OFS_CONTROL, v & 32'hfffe);
            rd(OFS_CONTROL, v & 32'hff1e, "control");
        end
        wr(OFS_TEMPERATURE, 32'h0);
        wr(OFS_CONTROL, 32'h0);
        repeat (10) @(posedge clk_sys);
        chk("slave sync", 32'h1, {31'h0, cmd_sync});
        repeat (6240) @(posedge clk_sys);
        rd(OFS_TEMPERATURE, {22'h0, TEMP}, "temperature");
        chk("slave sync idle", 32'h0, {31'h0, cmd_sync});
        link_established <= 1'b1;
        wr(OFS_LED_SELECT, 32'h1);
        repeat (20) @(posedge clk_sys);
        chk("led idle", 32'h0, {31'h0, led_on});
        host_word_rx <= 1'b1;
        @(posedge clk_sys);
        host_word_rx <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("led flash", 32'h1, {31'h0, led_on});
        repeat (110) @(posedge clk_sys);
        chk("led flash end", 32'h0, {31'h0, led_on});
        wr(OFS_CONTROL, 32'h0201);
        repeat (200) @(posedge clk_sys);
        wr(OFS_IDENTITY, 32'h0);
        repeat (40) @(posedge clk_sys);
        rd(OFS_CONTROL, 32'h0200, "control after soft reset");
        mc_en(32'h0000_8306);
        rd(OFS_STATUS, 32'h0400, "status sync high pc zero");
        wr(OFS_CONTROL, 32'h0210);
        @(posedge clk_sys);
        chk("sync enable", 32'h1, {31'h0, sync_out_oe});
        chk("master sync", 32'h1, {31'h0, cmd_sync});
        mc_en(32'h0000_4000);
        repeat (12) @(posedge clk_sys);
        chk("master sync low", 32'h0, {31'h0, cmd_sync});
        rd(OFS_STATUS, 32'h0400, "sync during delay");
        repeat (40) @(posedge clk_sys);
        rd(OFS_STATUS, 32'h0000, "sync after delay");
        wr(OFS_CONTROL, 32'h0002);
        mc_en(32'h0000_0002);
        repeat (30) @(posedge clk_sys);
        rd(OFS_INTEG_TIME, 32'h0, "itc paused");
        rd(OFS_STATUS, 32'h0200, "itc running");
        wr(OFS_CONTROL, 32'h0000);
        repeat (48) @(posedge clk_sys);
        mc_en(32'h0000_0004);
        rd(OFS_INTEG_TIME, 32'h5, "itc count");
        for (int i = 0; i < 8; i++) begin
            mc_en($random(seed));
        end
        wr(OFS_FIRMWARE, 32'h0);
        chk("boot", 32'h0, {31'h0, boot_n});
        test_done;
    end
endmodule // tb_seq_ctl_regs
